// ---- hw/dmeg_params.svh ----
// constants for the debug mailbox and erase guard block
// assumes inclusion by bare name from the design files
`ifndef DMEG_PARAMS_SVH
`define DMEG_PARAMS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define DMEG_OFS_INBOUND_WORD 12'h400
`define DMEG_OFS_INBOUND_FLAG 12'h404
`define DMEG_OFS_OUTBOUND_WORD 12'h480
`define DMEG_OFS_OUTBOUND_FLAG 12'h484
`define DMEG_OFS_WIPE_LOCK 12'h500
`define DMEG_OFS_UNGUARD_KEY 12'h504
`define DMEG_OFS_IRQ_STATUS 12'h600
`define DMEG_OFS_IRQ_MASK 12'h604

// ****************************************
// widths, reset values and field positions
// ****************************************
`define DMEG_ADDR_W 12
`define DMEG_DATA_W 32
`define DMEG_WORD_RESET 32'h0000_0000
`define DMEG_KEY_ZERO 32'h0000_0000
`define DMEG_FLAG_RESET 1'b0
`define DMEG_FLAG_BIT 0
`define DMEG_IRQ_W 3
`define DMEG_IRQ_RESET 3'h0
`define DMEG_IRQ_INBOUND 0
`define DMEG_IRQ_OUTBOUND 1
`define DMEG_IRQ_WIPE 2

`endif

// ---- hw/dmeg_pkg.sv ----
// types shared by the debug mailbox and erase guard files
// assumes dmeg_params.svh on the include path
package dmeg_pkg;
  `include "dmeg_params.svh"

  typedef logic [`DMEG_DATA_W-1:0] dmeg_word_t;
  typedef logic [`DMEG_ADDR_W-1:0] dmeg_addr_t;

  // erase guard progress
  typedef enum logic [1:0] {
    DMEG_GUARD_IDLE,
    DMEG_GUARD_LAUNCH,
    DMEG_GUARD_WAIT
  } dmeg_guard_e;
endpackage : dmeg_pkg

// ---- hw/dmeg_mbox_if.sv ----
// carrier between the top and the mailbox slot modules
// assumes one clock domain, owned by the top
interface dmeg_mbox_if;
  dmeg_pkg::dmeg_word_t wr_data;
  logic wr;
  logic rd;
  dmeg_pkg::dmeg_word_t word;
  logic pending;
  logic fill_evt;

  modport slot (
    input wr_data,
    input wr,
    input rd,
    output word,
    output pending,
    output fill_evt
  );
  modport owner (
    output wr_data,
    output wr,
    output rd,
    input word,
    input pending,
    input fill_evt
  );
endinterface : dmeg_mbox_if

// ---- hw/dmeg_mbox_slot.sv ----
// one-word mailbox with a pending flag
// assumes the writer and the reader are joined through dmeg_mbox_if
`include "dmeg_params.svh"

module dmeg_mbox_slot (
  input wire logic mclk,
  input wire logic rst,
  dmeg_mbox_if.slot mb
);

  // ****************************************
  // word storage
  // ****************************************
  // word held in a register so reads never see a half update
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mb.word <= `DMEG_WORD_RESET;
    end else if (mb.wr) begin
      mb.word <= mb.wr_data;
    end
  end

  // ****************************************
  // pending flag
  // ****************************************
  // a write beside a read keeps the flag set: new data must not vanish
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mb.pending <= `DMEG_FLAG_RESET;
    end else if (mb.wr) begin
      mb.pending <= 1'b1;
    end else if (mb.rd) begin
      mb.pending <= 1'b0;
    end
  end

  assign mb.fill_evt = mb.wr; // one pulse per deposit
endmodule : dmeg_mbox_slot

// ---- hw/dmeg_top.sv ----
// cpu-side register block of the debug mailbox and erase guard
// assumes a single-cycle register port and a debugger port on mclk
// assumes the eraser raises wipe_busy in the cycle after a launch
//
// How it works
// - cpu reads inbound word, read-only
// - cpu inbound read clears inbound pending
// - inbound flag shows debugger word waiting
// - outbound word is cpu read-write
// - cpu outbound write sets outbound pending
// - outbound flag shows word not yet collected
// - lock makes key register read-only
// - lock clears only by reset
// - key write lifts guard and starts wipe
// - wipe only on equal non-zero keys
//
// Strobed register access is this design's own decision.
`include "dmeg_params.svh"

module dmeg_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`DMEG_ADDR_W-1:0] reg_addr,
  input wire logic [`DMEG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`DMEG_DATA_W-1:0] reg_rdata,
  input wire logic [`DMEG_DATA_W-1:0] dbg_tx_word,
  input wire logic dbg_tx_wr,
  input wire logic dbg_rx_rd,
  output logic [`DMEG_DATA_W-1:0] dbg_rx_word,
  output logic dbg_rx_pending,
  output logic dbg_tx_pending,
  input wire logic [`DMEG_DATA_W-1:0] dbg_key,
  input wire logic dbg_key_wr,
  input wire logic wipe_busy,
  output logic full_wipe_start,
  output logic erase_guard_lifted,
  output logic irq
);

  // ****************************************
  // address decode
  // ****************************************
  // one-hot strobes of the cpu register map; full-width compares so
  // aliases in the upper address bits never hit
  logic hit_in_word;
  logic hit_in_flag;
  logic hit_out_word;
  logic hit_out_flag;
  logic hit_lock;
  logic hit_key;
  logic hit_status;
  logic hit_mask;

  // only the cpu-side map is decoded here; debugger registers have no
  // address on this port at all
  assign hit_in_word = (reg_addr == `DMEG_OFS_INBOUND_WORD);
  assign hit_in_flag = (reg_addr == `DMEG_OFS_INBOUND_FLAG);
  assign hit_out_word = (reg_addr == `DMEG_OFS_OUTBOUND_WORD);
  assign hit_out_flag = (reg_addr == `DMEG_OFS_OUTBOUND_FLAG);
  assign hit_lock = (reg_addr == `DMEG_OFS_WIPE_LOCK);
  assign hit_key = (reg_addr == `DMEG_OFS_UNGUARD_KEY);
  // interrupt status and mask sit above the mailbox and lock words
  assign hit_status = (reg_addr == `DMEG_OFS_IRQ_STATUS);
  assign hit_mask = (reg_addr == `DMEG_OFS_IRQ_MASK);

  // ****************************************
  // mailboxes
  // ****************************************
  dmeg_mbox_if inb ();
  dmeg_mbox_if outb ();

  // inbound: debugger fills, cpu drains; cpu writes are ignored
  assign inb.wr_data = dbg_tx_word;
  assign inb.wr = dbg_tx_wr;
  assign inb.rd = reg_rd && hit_in_word;
  // outbound: cpu fills, debugger drains
  assign outb.wr_data = reg_wdata;
  assign outb.wr = reg_wr && hit_out_word;
  assign outb.rd = dbg_rx_rd;

  // both slots are alike; only the wiring above names the direction
  dmeg_mbox_slot u_inbound (
    .mclk(mclk),
    .rst(rst),
    .mb(inb.slot)
  );

  dmeg_mbox_slot u_outbound (
    .mclk(mclk),
    .rst(rst),
    .mb(outb.slot)
  );

  // ****************************************
  // debugger port
  // ****************************************
  // word and both flags come straight from slot registers, so the
  // debugger never sees a combinational path from the cpu bus
  assign dbg_rx_word = outb.word;
  assign dbg_rx_pending = outb.pending;
  assign dbg_tx_pending = inb.pending;

  // ****************************************
  // erase guard lock and keys
  // ****************************************
  // lock and both key halves reset to zero, so a fresh device holds
  // no usable key until both sides write one
  logic lock_r;
  dmeg_pkg::dmeg_word_t cpu_key_r;
  dmeg_pkg::dmeg_word_t dbg_key_r;

  // write-one-to-set; nothing but reset brings it back to zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lock_r <= `DMEG_FLAG_RESET;
    end else if (reg_wr && hit_lock && reg_wdata[`DMEG_FLAG_BIT]) begin
      lock_r <= 1'b1;
    end
  end

  // ****************************************
  // key registers
  // ****************************************
  // cpu key is frozen once locked; a refused write leaves no trace, the
  // cpu only notices it by reading the key back
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cpu_key_r <= `DMEG_KEY_ZERO;
    end else if (reg_wr && hit_key && !lock_r) begin
      cpu_key_r <= reg_wdata;
    end
  end

  // debugger key is written over its own port only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dbg_key_r <= `DMEG_KEY_ZERO;
    end else if (dbg_key_wr) begin
      dbg_key_r <= dbg_key;
    end
  end

  // ****************************************
  // key check
  // ****************************************
  logic keys_match;
  logic key_evt;
  logic key_evt_r;
  // zero keys never match, so a reset device cannot wipe itself
  assign keys_match = (cpu_key_r != `DMEG_KEY_ZERO)
                   && (cpu_key_r == dbg_key_r);
  // an accepted key write from either side re-arms a check one cycle later
  assign key_evt = (reg_wr && hit_key && !lock_r) || dbg_key_wr;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      key_evt_r <= `DMEG_FLAG_RESET;
    end else begin
      key_evt_r <= key_evt;
    end
  end

  // ****************************************
  // erase launch sequencer
  // ****************************************
  dmeg_pkg::dmeg_guard_e guard_r;
  dmeg_pkg::dmeg_guard_e guard_nxt;

  // launch pulses once, then waits for the eraser to go idle
  always_comb begin
    guard_nxt = guard_r;
    unique case (guard_r)
      dmeg_pkg::DMEG_GUARD_IDLE: begin
        // a standing match alone never relaunches; a key write must come
        if (key_evt_r && keys_match) begin
          guard_nxt = dmeg_pkg::DMEG_GUARD_LAUNCH;
        end
      end
      dmeg_pkg::DMEG_GUARD_LAUNCH: begin
        // one cycle only, so the eraser sees a single pulse
        guard_nxt = dmeg_pkg::DMEG_GUARD_WAIT;
      end
      dmeg_pkg::DMEG_GUARD_WAIT: begin
        // an eraser that raises busy late lets this exit early
        if (!wipe_busy) begin
          guard_nxt = dmeg_pkg::DMEG_GUARD_IDLE;
        end
      end
      default: begin
        guard_nxt = dmeg_pkg::DMEG_GUARD_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      guard_r <= dmeg_pkg::DMEG_GUARD_IDLE;
    end else begin
      guard_r <= guard_nxt;
    end
  end

  assign full_wipe_start = (guard_r == dmeg_pkg::DMEG_GUARD_LAUNCH);

  // protection stays lifted until reset once a launch has happened
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      erase_guard_lifted <= `DMEG_FLAG_RESET;
    end else if (guard_r == dmeg_pkg::DMEG_GUARD_LAUNCH) begin
      erase_guard_lifted <= 1'b1;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  logic [`DMEG_IRQ_W-1:0] irq_evt;
  logic [`DMEG_IRQ_W-1:0] irq_status_r;
  logic [`DMEG_IRQ_W-1:0] irq_mask_r;
  logic [`DMEG_IRQ_W-1:0] irq_clr;

  // event pulses: debugger deposit, debugger pickup of a pending word,
  // and the launch pulse itself
  assign irq_evt[`DMEG_IRQ_INBOUND] = inb.fill_evt;
  assign irq_evt[`DMEG_IRQ_OUTBOUND] = outb.rd && outb.pending;
  assign irq_evt[`DMEG_IRQ_WIPE] = full_wipe_start;
  // write-one-to-clear: only the ones of the written word clear bits
  assign irq_clr = (reg_wr && hit_status) ? reg_wdata[`DMEG_IRQ_W-1:0]
                                          : `DMEG_IRQ_RESET;

  // set wins over a same-cycle clear so no event is lost
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_status_r <= `DMEG_IRQ_RESET;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_evt;
    end
  end

  // ****************************************
  // interrupt mask
  // ****************************************
  // plain read-write; reset masks all, so irq starts low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_mask_r <= `DMEG_IRQ_RESET;
    end else if (reg_wr && hit_mask) begin
      irq_mask_r <= reg_wdata[`DMEG_IRQ_W-1:0];
    end
  end

  // level straight from two registers, no glitch path from the bus
  assign irq = |(irq_status_r & irq_mask_r);

  // ****************************************
  // read data
  // ****************************************
  dmeg_pkg::dmeg_word_t rdata_nxt;

  // hits are one-hot, so the order of the ifs never matters; unmapped
  // addresses and unused upper bits of the flag words read zero
  always_comb begin
    rdata_nxt = `DMEG_WORD_RESET;
    if (hit_in_word) begin
      rdata_nxt = inb.word;
    end
    if (hit_in_flag) begin
      rdata_nxt[`DMEG_FLAG_BIT] = inb.pending;
    end
    if (hit_out_word) begin
      rdata_nxt = outb.word;
    end
    if (hit_out_flag) begin
      rdata_nxt[`DMEG_FLAG_BIT] = outb.pending;
    end
    if (hit_lock) begin
      rdata_nxt[`DMEG_FLAG_BIT] = lock_r;
    end
    if (hit_key) begin
      rdata_nxt = cpu_key_r;
    end
    if (hit_status) begin
      rdata_nxt[`DMEG_IRQ_W-1:0] = irq_status_r;
    end
    if (hit_mask) begin
      rdata_nxt[`DMEG_IRQ_W-1:0] = irq_mask_r;
    end
  end

  // data stands in the cycle after the strobe and holds until the next
  // read; reads never wait, so the cpu bus needs no ready signal
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `DMEG_WORD_RESET;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end
endmodule : dmeg_top

// ---- verif/dmeg_checker.sv ----
// port-level checks for the mailbox and erase guard top
// assumes one clock domain; bound onto dmeg_top below
`include "dmeg_params.svh"
module dmeg_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`DMEG_ADDR_W-1:0] reg_addr,
  input wire logic [`DMEG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`DMEG_DATA_W-1:0] reg_rdata,
  input wire logic [`DMEG_DATA_W-1:0] dbg_tx_word,
  input wire logic dbg_tx_wr,
  input wire logic dbg_rx_rd,
  input wire logic [`DMEG_DATA_W-1:0] dbg_rx_word,
  input wire logic dbg_rx_pending,
  input wire logic dbg_tx_pending,
  input wire logic dbg_key_wr,
  input wire logic full_wipe_start,
  input wire logic erase_guard_lifted
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // single domain, so one clock and reset
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rd_word;
    dbg_tx_wr ##1 (reg_rd && reg_addr == `DMEG_OFS_INBOUND_WORD && !dbg_tx_wr)
      |=> reg_rdata == $past(dbg_tx_word, 2);
  endproperty
  a_rd_word: assert property (p_rd_word) else $error("inbound word bad");
  property p_in_clr;
    reg_rd && reg_addr == `DMEG_OFS_INBOUND_WORD && !dbg_tx_wr
      |=> !dbg_tx_pending;
  endproperty
  a_in_clr: assert property (p_in_clr) else $error("inbound flag kept");
  property p_in_flag;
    reg_rd && reg_addr == `DMEG_OFS_INBOUND_FLAG
      |=> reg_rdata == {31'h0, $past(dbg_tx_pending)};
  endproperty
  a_in_flag: assert property (p_in_flag) else $error("inbound flag read");
  property p_wr_out;
    reg_wr && reg_addr == `DMEG_OFS_OUTBOUND_WORD
      |=> dbg_rx_word == $past(reg_wdata) && dbg_rx_pending;
  endproperty
  a_wr_out: assert property (p_wr_out) else $error("outbound write");
  property p_out_flag;
    reg_rd && reg_addr == `DMEG_OFS_OUTBOUND_FLAG
      |=> reg_rdata == {31'h0, $past(dbg_rx_pending)};
  endproperty
  a_out_flag: assert property (p_out_flag) else $error("outbound flag");
  property p_tx_set;
    dbg_tx_wr |=> dbg_tx_pending;
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("no inbound flag");
  property p_rx_clr;
    dbg_rx_rd && !(reg_wr && reg_addr == `DMEG_OFS_OUTBOUND_WORD)
      |=> !dbg_rx_pending;
  endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("outbound kept");
  property p_pulse;
    full_wipe_start |=> !full_wipe_start && erase_guard_lifted;
  endproperty
  a_pulse: assert property (p_pulse) else $error("wipe pulse bad");
  property p_launch;
    full_wipe_start |-> $past(reg_wr, 2) || $past(dbg_key_wr, 2);
  endproperty
  a_launch: assert property (p_launch) else $error("stray launch");
endmodule : dmeg_checker

bind dmeg_top dmeg_checker u_chk (.mclk(mclk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dbg_tx_word(dbg_tx_word),
  .dbg_tx_wr(dbg_tx_wr), .dbg_rx_rd(dbg_rx_rd), .dbg_rx_word(dbg_rx_word),
  .dbg_rx_pending(dbg_rx_pending), .dbg_tx_pending(dbg_tx_pending),
  .dbg_key_wr(dbg_key_wr), .full_wipe_start(full_wipe_start),
  .erase_guard_lifted(erase_guard_lifted));

// ---- verif/dmeg_dbg_model.sv ----
// debugger stand-in on the control access port side
// assumes the bench calls its tasks after reset release
module dmeg_dbg_model (
  input wire logic mclk,
  output dmeg_pkg::dmeg_word_t dbg_tx_word,
  output logic dbg_tx_wr,
  output logic dbg_rx_rd,
  output dmeg_pkg::dmeg_word_t dbg_key,
  output logic dbg_key_wr,
  input wire dmeg_pkg::dmeg_word_t dbg_rx_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // idle lines show junk, not a stale value
  // ****************************************
  initial begin
    dbg_tx_word = 32'hFFFF_FFFF;
    dbg_tx_wr = 1'b0;
    dbg_rx_rd = 1'b0;
    dbg_key = 32'hFFFF_FFFF;
    dbg_key_wr = 1'b0;
  end
  // deposit one word for the cpu
  task automatic send(input dmeg_pkg::dmeg_word_t w);
    @(posedge mclk);
    dbg_tx_word <= w;
    dbg_tx_wr <= 1'b1;
    @(posedge mclk);
    dbg_tx_wr <= 1'b0;
    dbg_tx_word <= ~w;
  endtask : send
  // pick up the cpu word
  task automatic collect(output dmeg_pkg::dmeg_word_t w);
    @(posedge mclk);
    dbg_rx_rd <= 1'b1;
    @(posedge mclk);
    w = dbg_rx_word; // taken at the edge that takes the pickup
    dbg_rx_rd <= 1'b0;
  endtask : collect
  // debugger half of the wipe key
  task automatic key(input dmeg_pkg::dmeg_word_t k);
    @(posedge mclk);
    dbg_key <= k;
    dbg_key_wr <= 1'b1;
    @(posedge mclk);
    dbg_key_wr <= 1'b0;
    dbg_key <= ~k;
  endtask : key
endmodule : dmeg_dbg_model

// ---- verif/dmeg_top_bench.sv ----
// self-checking bench for the mailbox and erase guard top
// assumes dmeg_checker is bound and dmeg_dbg_model drives the far side
`include "dmeg_params.svh"
module dmeg_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  dmeg_pkg::dmeg_addr_t reg_addr = 12'h000;
  dmeg_pkg::dmeg_word_t reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic wipe_busy = 1'b0;
  dmeg_pkg::dmeg_word_t reg_rdata, dbg_tx_word, dbg_rx_word, dbg_key, v;
  logic dbg_tx_wr, dbg_rx_rd, dbg_rx_pending, dbg_tx_pending, dbg_key_wr;
  logic full_wipe_start, erase_guard_lifted, irq;
  int errors = 0;
  int comparisons = 0;
  int starts = 0;
  // ****************************************
  // clock, eraser stand-in, instances
  // ****************************************
  always #25 mclk = ~mclk;
  // eraser busy one cycle per launch; launches counted
  always @(posedge mclk) begin
    wipe_busy <= full_wipe_start;
    if (full_wipe_start === 1'b1) starts <= starts + 1;
  end
  dmeg_top u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dbg_tx_word(dbg_tx_word), .dbg_tx_wr(dbg_tx_wr),
    .dbg_rx_rd(dbg_rx_rd), .dbg_rx_word(dbg_rx_word),
    .dbg_rx_pending(dbg_rx_pending), .dbg_tx_pending(dbg_tx_pending),
    .dbg_key(dbg_key), .dbg_key_wr(dbg_key_wr), .wipe_busy(wipe_busy),
    .full_wipe_start(full_wipe_start),
    .erase_guard_lifted(erase_guard_lifted), .irq(irq));
  dmeg_dbg_model u_dbg (.mclk(mclk), .dbg_tx_word(dbg_tx_word),
    .dbg_tx_wr(dbg_tx_wr), .dbg_rx_rd(dbg_rx_rd), .dbg_key(dbg_key),
    .dbg_key_wr(dbg_key_wr), .dbg_rx_word(dbg_rx_word));
  // one comparison, counted
  task automatic chk(input dmeg_pkg::dmeg_word_t seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input dmeg_pkg::dmeg_addr_t a, dmeg_pkg::dmeg_word_t d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand from the cycle after the strobe until the next read
  task automatic rdc(input dmeg_pkg::dmeg_addr_t a, dmeg_pkg::dmeg_word_t e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rdc
  // every mailbox, lock and key register plus an unmapped hole reads zero
  task automatic t_reset();
    dmeg_pkg::dmeg_addr_t ofs[7] = '{12'h400, 12'h404, 12'h480, 12'h484,
      12'h500, 12'h504, 12'h700};
    foreach (ofs[i]) rdc(ofs[i], 32'h0);
  endtask : t_reset
  task automatic t_inbound();
    u_dbg.send(32'hA5C3_1E77);
    rdc(`DMEG_OFS_INBOUND_FLAG, 32'h1);
    wr(`DMEG_OFS_INBOUND_WORD, 32'h0000_FFFF);
    rdc(`DMEG_OFS_INBOUND_WORD, 32'hA5C3_1E77);
    rdc(`DMEG_OFS_INBOUND_FLAG, 32'h0);
    // a read right behind a deposit must already see the new word
    fork
      u_dbg.send(32'h3C96_0F0F);
      begin
        @(posedge mclk);
        rdc(`DMEG_OFS_INBOUND_WORD, 32'h3C96_0F0F);
      end
    join
    rdc(`DMEG_OFS_INBOUND_FLAG, 32'h0);
  endtask : t_inbound
  task automatic t_outbound();
    wr(`DMEG_OFS_OUTBOUND_WORD, 32'h1234_ABCD);
    rdc(`DMEG_OFS_OUTBOUND_FLAG, 32'h1);
    rdc(`DMEG_OFS_OUTBOUND_WORD, 32'h1234_ABCD);
    u_dbg.collect(v);
    chk(v, 32'h1234_ABCD);
    rdc(`DMEG_OFS_OUTBOUND_FLAG, 32'h0);
  endtask : t_outbound
  // mismatch, match, zero keys, then locked key register
  task automatic t_wipe();
    u_dbg.key(32'h5A5A_0001);
    wr(`DMEG_OFS_UNGUARD_KEY, 32'h5A5A_0002);
    wr(`DMEG_OFS_UNGUARD_KEY, 32'h5A5A_0001);
    repeat (3) @(posedge mclk);
    chk(starts, 1);
    chk(erase_guard_lifted, 1'b1);
    u_dbg.key(32'h0);
    wr(`DMEG_OFS_UNGUARD_KEY, 32'h0);
    wr(`DMEG_OFS_WIPE_LOCK, 32'h1);
    wr(`DMEG_OFS_WIPE_LOCK, 32'h0);
    rdc(`DMEG_OFS_WIPE_LOCK, 32'h1);
    wr(`DMEG_OFS_UNGUARD_KEY, 32'h5A5A_0003);
    rdc(`DMEG_OFS_UNGUARD_KEY, 32'h0);
    u_dbg.key(32'h5A5A_0003);
    repeat (3) @(posedge mclk);
    chk(starts, 1);
  endtask : t_wipe
  // all three events are pending by now
  task automatic t_irq();
    rdc(`DMEG_OFS_IRQ_STATUS, 32'h7);
    chk(irq, 1'b0);
    wr(`DMEG_OFS_IRQ_MASK, 32'h2);
    #1 chk(irq, 1'b1);
    wr(`DMEG_OFS_IRQ_STATUS, 32'h2);
    #1 chk(irq, 1'b0);
    rdc(`DMEG_OFS_IRQ_STATUS, 32'h5);
  endtask : t_irq
  // a fresh reset is the only way out of the lock
  task automatic t_relock();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rdc(`DMEG_OFS_WIPE_LOCK, 32'h0);
    chk(erase_guard_lifted, 1'b0);
    wr(`DMEG_OFS_UNGUARD_KEY, 32'h5A5A_0004);
    rdc(`DMEG_OFS_UNGUARD_KEY, 32'h5A5A_0004);
  endtask : t_relock
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_inbound();
    t_outbound();
    t_wipe();
    t_irq();
    t_relock();
    end_of_test();
  end
  // watchdog, about thirty times the expected run
  initial begin
    #(3000 * 50);
    errors++;
    end_of_test();
  end
endmodule : dmeg_top_bench
